/* rtl/scf_pkg.sv */
// serial command framer: shared constants, state encodings, state record
// assumes a byte-wide receiver and transmitter on the same clock
// Contract
// - frames are DLE STX data DLE ETX check
// - payload 0x10 doubled on send, collapsed on receive
// - fields: operation, count high, count low, object, flags, data
// - unpermitted operation gets no response; the code still answers DLE ACK and skips only force and deactivate
// - 16-bit count 0..FF, zero unlimited, default one
// - bad check: answer DLE NAK, discard
// - good check: answer DLE ACK, then execute
// - unexecutable good frame dropped silently
// - results go back as framed packets
// - host NAK causes up to three resends
// - new command stops a running stream
// - DLE ENQ answered with DLE ACK
// - check byte is negated modulo-256 data sum
// - doubled 0x10 counted once in sum
// - malformed command gets only the acknowledge
// - deactivate command releases all forced outputs
// - results follow acknowledge, same framing
package scf_pkg;

    // ------------------------------------------------------------
    // link control codes
    // ------------------------------------------------------------
    localparam logic [7:0] SCF_DLE = 8'h10;
    localparam logic [7:0] SCF_STX = 8'h02;
    localparam logic [7:0] SCF_ETX = 8'h03;
    localparam logic [7:0] SCF_ENQ = 8'h05;
    localparam logic [7:0] SCF_ACK = 8'h06;
    localparam logic [7:0] SCF_NAK = 8'h15;

    // ------------------------------------------------------------
    // operations and objects
    // ------------------------------------------------------------
    localparam logic [7:0] SCF_OP_ECHO  = 8'h01;
    localparam logic [7:0] SCF_OP_FORCE = 8'h02;
    localparam logic [7:0] SCF_OP_DEACT = 8'h0b;
    localparam logic [7:0] SCF_OBJ_OUTS = 8'h06;

    // ------------------------------------------------------------
    // sizes and field positions
    // ------------------------------------------------------------
    localparam int          SCF_AW        = 6;     // payload memory
    localparam logic [6:0]  SCF_MEM_DEPTH = 7'd64;
    localparam logic [6:0]  SCF_LEN_OP    = 7'd1;  // operation only
    localparam logic [6:0]  SCF_DATA_POS  = 7'd3;  // echo data start
    localparam logic [6:0]  SCF_HDR_KEEP  = 7'd6;  // bytes held in regs
    localparam logic [6:0]  SCF_FRC_LEN   = 7'd6;
    localparam logic [7:0]  SCF_NT_DEF    = 8'h01; // count when absent
    localparam logic [1:0]  SCF_RETRY_MAX = 2'd3;
    localparam int          SCF_NOUT      = 14;

    // ------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        RX_IDLE = 5'b00001,
        RX_ESC  = 5'b00010,
        RX_DATA = 5'b00100,
        RX_DESC = 5'b01000,
        RX_CHK  = 5'b10000
    } scf_rx_e;

    typedef enum logic [9:0] {
        TX_IDLE  = 10'b0000000001,
        TX_CTL   = 10'b0000000010,
        TX_HDR   = 10'b0000000100,
        TX_FETCH = 10'b0000001000,
        TX_BODY  = 10'b0000010000,
        TX_STUF  = 10'b0000100000,
        TX_TRL   = 10'b0001000000,
        TX_ETXS  = 10'b0010000000,
        TX_CHKB  = 10'b0100000000,
        TX_WAIT  = 10'b1000000000
    } scf_tx_e;

    typedef struct packed {
        scf_rx_e              rx;
        logic [7:0]           sum;
        logic [6:0]           len;
        logic                 ovf;
        logic [5:0][7:0]      hb;
        logic                 ctl_req;
        logic [7:0]           ctl_code;
        scf_tx_e              tx;
        logic                 back_wait;
        logic                 pkt_go;
        logic [6:0]           rd_addr;
        logic [6:0]           end_addr;
        logic [7:0]           tsum;
        logic [7:0]           rep;
        logic                 rep_inf;
        logic [1:0]           retry;
        logic [7:0]           tx_byte;
        logic                 tx_valid;
        logic                 busy;      // result stream pending, or transmitter not idle
        logic [SCF_NOUT-1:0]  f_on;
        logic [SCF_NOUT-1:0]  f_off;
        logic [SCF_NOUT-1:0]  frc_en;
        logic [SCF_NOUT-1:0]  frc_val;
    } scf_st_s;

    localparam scf_st_s SCF_ST_RST = '{rx: RX_IDLE, tx: TX_IDLE, default: '0};

endpackage

/* rtl/scf_byte_mem.sv */
// payload store for one received command frame
// assumes a single clock; read data is registered, one cycle late
`timescale 1ns/1ps
module scf_byte_mem
    import scf_pkg::*;
#(
    parameter int AW = SCF_AW
) (
    // clock
    input  wire logic          clk_sys,
    // write side
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // read side
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [7:0] mem [0:(1<<AW)-1];  // no reset: contents are payload only

    // write port and registered read port
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

/* rtl/scf_framer.sv */
// serial command framer: receives escaped command frames, checks them,
// answers ACK/NAK, runs echo/force/deactivate and sends framed results
// assumes byte streams from a uart on clk_sys; baud logic lives outside
`timescale 1ns/1ps
module scf_framer
    import scf_pkg::*;
(
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    // received bytes
    input  wire logic [7:0]          rx_byte,
    input  wire logic                rx_valid,
    // bytes to send
    output logic      [7:0]          tx_byte,
    output logic                     tx_valid,
    input  wire logic                tx_ready,
    // module status
    input  wire logic                host_sel,
    input  wire logic                setup_mode,
    // forced discrete outputs and stream busy flag
    output logic      [SCF_NOUT-1:0] frc_en,
    output logic      [SCF_NOUT-1:0] frc_val,
    output logic                     stream_busy
);

    // ------------------------------------------------------------
    // state and helpers
    // ------------------------------------------------------------
    scf_st_s             s_r;        // all registered state
    scf_st_s             s_nxt;      // next value
    logic                free;       // output slot can take a byte
    logic                store;      // payload byte this cycle
    logic                fstart;     // DLE STX seen
    logic                fdone;      // check byte seen
    logic                good;       // check byte matched
    logic                h_ack;      // host DLE ACK
    logic                h_nak;      // host DLE NAK
    logic                ctl_new;    // answer requested this cycle
    logic                permit;     // host selected, not in setup
    logic                is_echo;    // well formed echo
    logic                is_frc;     // well formed force
    logic                is_deact;   // well formed deactivate
    logic                mem_we;     // payload write
    logic [7:0]          chk_sum;    // sum including check byte
    logic [7:0]          rd_data;    // payload read data
    logic [SCF_NOUT-1:0] fl;         // force select flags
    logic [SCF_NOUT-1:0] fd;         // force on/off data

    assign chk_sum = s_r.sum + rx_byte;
    assign permit  = host_sel && !setup_mode;
    assign fl      = {s_r.hb[3][5:0], s_r.hb[2]};
    assign fd      = {s_r.hb[5][5:0], s_r.hb[4]};

    // ------------------------------------------------------------
    // command validity
    // ------------------------------------------------------------
    // field order
    // echo: op alone, or op, count high, count low, data
    // count range check
    assign is_echo  = (s_r.hb[0] == SCF_OP_ECHO) &&
                      ((s_r.len == SCF_LEN_OP) ||
                       ((s_r.len >= SCF_DATA_POS) && (s_r.hb[1] == 8'h00)));
    assign is_frc   = (s_r.hb[0] == SCF_OP_FORCE) &&
                      (s_r.len == SCF_FRC_LEN) &&
                      (s_r.hb[1] == SCF_OBJ_OUTS);
    assign is_deact = (s_r.hb[0] == SCF_OP_DEACT) &&
                      (s_r.len == SCF_LEN_OP);

    // ------------------------------------------------------------
    // payload memory
    // ------------------------------------------------------------
    scf_byte_mem #(
        .AW (SCF_AW)
    ) u_mem (
        .clk_sys (clk_sys),
        .we      (mem_we),
        .waddr   (s_r.len[SCF_AW-1:0]),
        .wdata   (rx_byte),
        .raddr   (s_r.rd_addr[SCF_AW-1:0]),
        .rdata   (rd_data)
    );

    // ------------------------------------------------------------
    // next state: receiver, command execution, transmitter
    // ------------------------------------------------------------
    always_comb begin
        s_nxt  = s_r;
        store  = 1'b0;
        fstart = 1'b0;
        fdone  = 1'b0;
        good   = 1'b0;
        h_ack  = 1'b0;
        h_nak  = 1'b0;
        ctl_new = 1'b0;
        mem_we = 1'b0;
        free   = !s_r.tx_valid || tx_ready;
        // byte taken by the uart
        if (s_r.tx_valid && tx_ready) begin
            s_nxt.tx_valid = 1'b0;
        end

        // receiver: escape decode
        if (rx_valid) begin
            unique case (s_r.rx)
                RX_IDLE: begin
                    if (rx_byte == SCF_DLE) begin
                        s_nxt.rx = RX_ESC;
                    end
                end
                RX_ESC: begin
                    s_nxt.rx = RX_IDLE;
                    if (rx_byte == SCF_STX) begin
                        fstart = 1'b1;
                    end else if (rx_byte == SCF_ENQ) begin
                        ctl_new        = 1'b1;
                        s_nxt.ctl_req  = 1'b1;
                        s_nxt.ctl_code = SCF_ACK;
                    end else if (rx_byte == SCF_ACK) begin
                        h_ack = 1'b1;
                    end else if (rx_byte == SCF_NAK) begin
                        h_nak = 1'b1;
                    end else if (rx_byte == SCF_DLE) begin
                        s_nxt.rx = RX_ESC;
                    end
                end
                RX_DATA: begin
                    if (rx_byte == SCF_DLE) begin
                        s_nxt.rx = RX_DESC;
                    end else begin
                        store = 1'b1;
                    end
                end
                RX_DESC: begin
                    if (rx_byte == SCF_DLE) begin
                        store    = 1'b1;
                        s_nxt.rx = RX_DATA;
                    end else if (rx_byte == SCF_STX) begin
                        fstart = 1'b1;
                    end else if (rx_byte == SCF_ETX) begin
                        s_nxt.rx = RX_CHK;
                    end else begin
                        // broken escape: drop the frame silently
                        s_nxt.rx = RX_IDLE;
                    end
                end
                RX_CHK: begin
                    s_nxt.rx = RX_IDLE;
                    fdone    = 1'b1;
                end
                default: begin
                    s_nxt.rx = RX_IDLE;
                end
            endcase
        end

        // frame start resets the running sum and count
        if (fstart) begin
            s_nxt.rx  = RX_DATA;
            s_nxt.sum = 8'h00;
            s_nxt.len = 7'd0;
            s_nxt.ovf = 1'b0;
        end

        if (store) begin
            s_nxt.sum = s_r.sum + rx_byte;
            if (s_r.len < SCF_HDR_KEEP) begin
                s_nxt.hb[s_r.len[2:0]] = rx_byte;
            end
            // long frames are marked and later dropped
            if (s_r.len == SCF_MEM_DEPTH) begin
                s_nxt.ovf = 1'b1;
            end else begin
                mem_we    = 1'b1;
                s_nxt.len = s_r.len + 7'd1;
            end
        end

        if (fdone) begin
            good           = (chk_sum == 8'h00);
            ctl_new        = 1'b1;
            s_nxt.ctl_req  = 1'b1;
            s_nxt.ctl_code = good ? SCF_ACK : SCF_NAK;
        end

        if (good && !s_r.ovf) begin
            if (is_echo) begin
                s_nxt.rep      = (s_r.len == SCF_LEN_OP) ? SCF_NT_DEF
                                                         : s_r.hb[2];
                s_nxt.rep_inf  = (s_r.len != SCF_LEN_OP) &&
                                 (s_r.hb[2] == 8'h00);
                s_nxt.end_addr = s_r.len;
                s_nxt.retry    = 2'd0;
                s_nxt.pkt_go   = 1'b1;
            end else if (is_frc && permit) begin
                // off wins over on; forces accumulate
                s_nxt.f_on  = s_r.f_on | (fl & fd);
                s_nxt.f_off = s_r.f_off | (fl & ~fd);
            end else if (is_deact && permit) begin
                s_nxt.f_on  = '0;
                s_nxt.f_off = '0;
            end
        end

        // transmitter
        unique case (s_r.tx)
            TX_IDLE: begin
                if (free && s_nxt.ctl_req) begin
                    s_nxt.tx_byte  = SCF_DLE;
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.tx       = TX_CTL;
                end else if (free && s_nxt.pkt_go && !fstart) begin
                    s_nxt.tx_byte  = SCF_DLE;
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.pkt_go   = 1'b0;
                    s_nxt.tx       = TX_HDR;
                end
            end
            TX_CTL: begin
                if (free) begin
                    // send the pending code; a request raised in this
                    // same cycle wins over the clear and goes next
                    s_nxt.tx_byte   = s_r.ctl_code;
                    s_nxt.tx_valid  = 1'b1;
                    s_nxt.ctl_req   = ctl_new;
                    s_nxt.back_wait = 1'b0;
                    s_nxt.tx        = s_r.back_wait ? TX_WAIT : TX_IDLE;
                end
            end
            TX_HDR: begin
                if (free) begin
                    s_nxt.tx_byte  = SCF_STX;
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.rd_addr  = SCF_DATA_POS;
                    s_nxt.tsum     = 8'h00;
                    s_nxt.tx       = TX_FETCH;
                end
            end
            TX_FETCH: begin
                // one cycle for the registered memory read
                s_nxt.tx = (s_r.rd_addr < s_r.end_addr) ? TX_BODY : TX_TRL;
            end
            TX_BODY: begin
                if (free) begin
                    s_nxt.tx_byte  = rd_data;
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.tsum     = s_r.tsum + rd_data;
                    if (rd_data == SCF_DLE) begin
                        s_nxt.tx = TX_STUF;
                    end else begin
                        s_nxt.rd_addr = s_r.rd_addr + 7'd1;
                        s_nxt.tx      = TX_FETCH;
                    end
                end
            end
            TX_STUF: begin
                if (free) begin
                    s_nxt.tx_byte  = SCF_DLE;
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.rd_addr  = s_r.rd_addr + 7'd1;
                    s_nxt.tx       = TX_FETCH;
                end
            end
            TX_TRL: begin
                if (free) begin
                    s_nxt.tx_byte  = SCF_DLE;
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.tx       = TX_ETXS;
                end
            end
            TX_ETXS: begin
                if (free) begin
                    s_nxt.tx_byte  = SCF_ETX;
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.tx       = TX_CHKB;
                end
            end
            TX_CHKB: begin
                if (free) begin
                    s_nxt.tx_byte  = 8'h00 - s_r.tsum;
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.tx       = TX_WAIT;
                end
            end
            TX_WAIT: begin
                // resend on NAK, at most three times
                if (h_nak && (s_r.retry != SCF_RETRY_MAX)) begin
                    s_nxt.retry  = s_r.retry + 2'd1;
                    s_nxt.pkt_go = 1'b1;
                    s_nxt.tx     = TX_IDLE;
                end else if (h_ack || h_nak) begin
                    // packet done or dropped: next repetition
                    s_nxt.retry = 2'd0;
                    s_nxt.tx    = TX_IDLE;
                    if (s_r.rep_inf || (s_r.rep > 8'h01)) begin
                        s_nxt.pkt_go = 1'b1;
                        if (!s_r.rep_inf) begin
                            s_nxt.rep = s_r.rep - 8'h01;
                        end
                    end
                end else if (free && s_nxt.ctl_req) begin
                    // link answers may interleave while waiting
                    s_nxt.tx_byte   = SCF_DLE;
                    s_nxt.tx_valid  = 1'b1;
                    s_nxt.back_wait = 1'b1;
                    s_nxt.tx        = TX_CTL;
                end
            end
            default: begin
                s_nxt.tx = TX_IDLE;
            end
        endcase

        if (fstart) begin
            s_nxt.pkt_go    = 1'b0;
            s_nxt.back_wait = 1'b0;
            if (s_nxt.tx != TX_CTL) begin
                s_nxt.tx = TX_IDLE;
            end
        end

        // registered force outputs, off has priority
        s_nxt.frc_en  = s_nxt.f_on | s_nxt.f_off;
        s_nxt.frc_val = s_nxt.f_on & ~s_nxt.f_off;
        // stream flag kept in a flop so the pin has no gate behind it
        s_nxt.busy    = s_nxt.pkt_go || (s_nxt.tx != TX_IDLE);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= SCF_ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state register
    assign tx_byte     = s_r.tx_byte;
    assign tx_valid    = s_r.tx_valid;
    assign frc_en      = s_r.frc_en;
    assign frc_val     = s_r.frc_val;
    assign stream_busy = s_r.busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    property p_nak_bad;
        rx_valid && (s_r.rx == RX_CHK) && (chk_sum != 8'h00)
        |=> s_r.ctl_req && (s_r.ctl_code == SCF_NAK) && !s_r.pkt_go;
    endproperty
    a_nak_bad: assert property (p_nak_bad)
        else $error("bad check not answered with NAK");

    property p_ack_good;
        rx_valid && (s_r.rx == RX_CHK) && (chk_sum == 8'h00)
        |=> s_r.ctl_req && (s_r.ctl_code == SCF_ACK);
    endproperty
    a_ack_good: assert property (p_ack_good)
        else $error("good check not answered with ACK");

    property p_enq;
        rx_valid && (s_r.rx == RX_ESC) && (rx_byte == SCF_ENQ)
        |=> s_r.ctl_req && (s_r.ctl_code == SCF_ACK);
    endproperty
    a_enq: assert property (p_enq)
        else $error("enquiry not answered");

    property p_destuff;
        rx_valid && (s_r.rx == RX_DESC) && (rx_byte == SCF_DLE)
        |=> (s_r.sum == $past(s_r.sum) + 8'h10) && (s_r.rx == RX_DATA);
    endproperty
    a_destuff: assert property (p_destuff)
        else $error("doubled escape not counted once");

    property p_stuff;
        (s_r.tx == TX_BODY) && free && (rd_data == SCF_DLE) && !fstart
        |=> (s_r.tx_byte == SCF_DLE) && (s_r.tx == TX_STUF);
    endproperty
    a_stuff: assert property (p_stuff)
        else $error("escape value not followed by stuffing");

    property p_stuff_dbl;
        (s_r.tx == TX_STUF) && free && !fstart
        |=> (s_r.tx_byte == SCF_DLE) && s_r.tx_valid &&
            (s_r.tx == TX_FETCH);
    endproperty
    a_stuff_dbl: assert property (p_stuff_dbl)
        else $error("stuffed escape not sent twice");

    property p_retry;
        (s_r.tx == TX_WAIT) && h_nak && (s_r.retry != SCF_RETRY_MAX)
        |=> (s_r.retry == $past(s_r.retry) + 2'd1) && s_r.pkt_go;
    endproperty
    a_retry: assert property (p_retry)
        else $error("rejected packet not resent");

    property p_deact;
        fdone && good && !s_r.ovf && is_deact && permit
        |=> ##1 (frc_en == '0);
    endproperty
    a_deact: assert property (p_deact)
        else $error("forces not released");

    property p_noperm;
        fdone && good && is_frc && !permit
        |=> $stable(s_r.f_on) && $stable(s_r.f_off);
    endproperty
    a_noperm: assert property (p_noperm)
        else $error("unpermitted force acted");

    property p_kill;
        fstart |=> !s_r.pkt_go && (s_r.tx inside {TX_IDLE, TX_CTL});
    endproperty
    a_kill: assert property (p_kill)
        else $error("stream survived new command");

    property p_endless;
        fdone && good && !s_r.ovf && is_echo &&
        (s_r.len >= SCF_DATA_POS) && (s_r.hb[2] == 8'h00)
        |=> s_r.rep_inf && s_r.pkt_go;
    endproperty
    a_endless: assert property (p_endless)
        else $error("zero count not endless");

    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
    endproperty
    a_hold: assert property (p_hold)
        else $error("unsent byte changed");

    c_echo:  cover property (fdone && good && is_echo);
    c_nak:   cover property ((s_r.tx == TX_WAIT) && h_nak);
    c_deact: cover property (fdone && good && is_deact && permit);

endmodule

/* verif/scf_host_model.sv */
// host model: takes framer bytes, stalling at random
// assumes the bench seeds $urandom once
`timescale 1ns/1ps
module scf_host_model (
    // uart side
    input  wire logic       clk_sys,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // byte taken
    output logic            got,
    output logic [7:0]      got_byte
);
    // a slow host proves each byte stands until taken
    initial tx_ready = 1'b0;
    always @(posedge clk_sys) begin
        #2 tx_ready = ($urandom % 4) != 0;
    end
    assign got      = tx_valid & tx_ready;
    assign got_byte = tx_byte;
endmodule

/* verif/scf_framer_tb_top.sv */
// bench: host frames in, every reply byte checked in order
// assumes the host model for tx_ready
`timescale 1ns/1ps
module scf_framer_tb_top;
    import scf_pkg::*;
    // ----
    // signals
    // ----
    logic        clk_sys = 0, rst_b = 0, rx_valid = 0;
    logic        host_sel = 1, setup_mode = 0;
    logic [7:0]  rx_byte = 0, tx_byte, got_byte, exp[$];
    logic [13:0] frc_en, frc_val, d;
    logic        tx_valid, tx_ready, got, stream_busy;
    int          n_errors = 0, tests_run = 0;
    always #25 clk_sys = ~clk_sys;
    scf_framer dut (.clk_sys(clk_sys), .rst_b(rst_b), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .host_sel(host_sel), .setup_mode(setup_mode),
        .frc_en(frc_en), .frc_val(frc_val), .stream_busy(stream_busy));
    scf_host_model host (.clk_sys(clk_sys), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .got(got),
        .got_byte(got_byte));
    // ----
    // tasks
    // ----
    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // oldest note against each byte the host takes
    always @(posedge clk_sys) if (got === 1'b1) begin
        if (exp.size() == 0) chk("extra", 16'hffff, {8'h0, got_byte});
        else chk("tx", {8'h0, exp.pop_front()}, {8'h0, got_byte});
    end
    // valid stays up between bytes, dropped only by idle
    task automatic sb(logic [7:0] b);
        rx_byte = b;
        rx_valid = 1;
        @(posedge clk_sys);
        #2;
    endtask
    task automatic idle(int n);
        rx_valid = 0;
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic ob(bit q, logic [7:0] b);
        if (q) exp.push_back(b);
        else sb(b);
    endtask
    task automatic pkt(bit q, logic [7:0] p[], logic [7:0] x);
        logic [7:0] s;
        s = 0;
        ob(q, 8'h10);
        ob(q, 8'h02);
        foreach (p[i]) begin
            s += p[i];
            ob(q, p[i]);
            if (p[i] == 8'h10) ob(q, 8'h10);
        end
        ob(q, 8'h10);
        ob(q, 8'h03);
        ob(q, (8'h0 - s) ^ x);
    endtask
    task automatic drain(string nm);
        int k;
        idle(1);
        for (k = 0; k < 3000 && exp.size() != 0; k++) @(posedge clk_sys);
        if (exp.size() != 0) begin
            n_errors++;
            $display("CHECK FAILED %s exp 0 got %0d", nm, exp.size());
            finish_test;
        end
        idle(40);
        $display("test %s done", nm);
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        void'($urandom(32'h2f370e05));
        repeat (20) @(posedge clk_sys);
        #2 rst_b = 1;
        sb(8'h10);
        sb(8'h02);
        exp = '{8'h10, 8'h15};
        pkt(0, '{8'h01, 8'h00, 8'h01, 8'h41}, 8'h01);
        drain("badchk");
        exp = '{8'h10, 8'h06};
        pkt(1, '{8'h41}, 0);
        pkt(0, '{8'h01, 8'h00, 8'h01, 8'h41}, 0);
        drain("echo");
        sb(8'h10);
        sb(8'h06);
        drain("ack");
        exp = '{8'h10, 8'h06};
        pkt(1, '{8'h10}, 0);
        pkt(0, '{8'h01, 8'h00, 8'h01, 8'h10}, 0);
        drain("stuffed");
        for (int i = 0; i < 4; i++) begin
            if (i < 3) pkt(1, '{8'h10}, 0);
            sb(8'h10);
            sb(8'h15);
            drain("resend");
        end
        for (int i = 0; i < 3; i++) begin
            host_sel = (i != 0);
            setup_mode = (i == 1);
            d = 14'($urandom);
            exp = '{8'h10, 8'h06};
            pkt(0, '{8'h02, 8'h06, 8'hff, 8'h3f, d[7:0], {2'b0, d[13:8]}}, 0);
            drain("force");
            chk("en", (i == 2) ? 16'h3fff : 16'h0, {2'b0, frc_en});
            if (i == 2) chk("val", {2'b0, d}, {2'b0, frc_val});
        end
        exp = '{8'h10, 8'h06};
        sb(8'h10);
        sb(8'h05);
        drain("enq");
        // count high set: malformed, only the acknowledge
        exp = '{8'h10, 8'h06};
        pkt(0, '{8'h01, 8'h01, 8'h01, 8'h41}, 0);
        drain("malformed");
        exp = '{8'h10, 8'h06};
        pkt(1, '{8'h41}, 0);
        pkt(0, '{8'h01, 8'h00, 8'h00, 8'h41}, 0);
        drain("endless");
        chk("busy", 16'h1, {15'h0, stream_busy});
        exp = '{8'h10, 8'h06};
        pkt(0, '{8'h0b}, 0);
        drain("deact");
        chk("busy", 16'h0, {15'h0, stream_busy});
        chk("en", 16'h0, {2'b0, frc_en});
        finish_test;
    end
endmodule
